// ==== cq_edge_select.sv ====
// module: edge picker for one external clock input
`timescale 1ns/10ps
`default_nettype none
module cq_edge_select
(
  input  wire logic       clk_i,   // system clock
  input  wire logic       rst_b_i, // sync reset, low active
  input  wire logic       ce_i,    // clock enable
  input  wire logic [2:0] mode_i,  // clock field of this input
  input  wire logic       pin_i,   // external clock input level
  output logic            hit_o,   // selected edge this cycle
  output logic            prev_o   // level one cycle earlier
);
  logic prev_reg;  // last sampled level
  logic prev_next; // its next value
  // ---------------------------------------------------------------
  // history of the pin
  // ---------------------------------------------------------------
  always_comb
  begin
    prev_next = ce_i ? pin_i : prev_reg;
  end
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      prev_reg <= 1'b0;
    else
      prev_reg <= prev_next;
  end
  // qualifier and off settings never give an edge
  assign hit_o  = cq_pkg::edge_hit(mode_i, pin_i, prev_reg);
  assign prev_o = prev_reg;
endmodule // cq_edge_select
`default_nettype wire

// ==== cq_pkg.sv ====
// package: constants, codes and helpers of the clock qualifier
`default_nettype none
package cq_pkg;
  // ---------------------------------------------------------------
  // clock field codes, one per external input
  // ---------------------------------------------------------------
  localparam logic [2:0] CLK_OFF  = 3'h0; // input unused
  localparam logic [2:0] CLK_RISE = 3'h1; // low-to-high edges clock
  localparam logic [2:0] CLK_FALL = 3'h2; // high-to-low edges clock
  localparam logic [2:0] CLK_BOTH = 3'h3; // every transition clocks
  localparam logic [2:0] CLK_HIGH = 3'h4; // gates other while high
  localparam logic [2:0] CLK_LOW  = 3'h5; // gates other while low
  // speed settings and count qualifier modes
  localparam logic [1:0] SPD_SLOW  = 2'h0;
  localparam logic [1:0] SPD_FAST  = 2'h1;
  localparam logic [1:0] SPD_VFAST = 2'h2;
  localparam logic [1:0] CNT_OFF    = 2'h0;
  localparam logic [1:0] CNT_STATES = 2'h1;
  localparam logic [1:0] CNT_TIME   = 2'h2;
  // ---------------------------------------------------------------
  // rate caps, in kHz, and least spacing in system cycles
  // ---------------------------------------------------------------
  localparam int SYS_KHZ   = 25000; // system clock rate
  localparam int SLOW_KHZ  = 16000;
  localparam int FAST_KHZ  = 20000;
  localparam int VFAST_KHZ = 25000;
  localparam logic [1:0] SLOW_CYC  =
    2'((SYS_KHZ + SLOW_KHZ - 1) / SLOW_KHZ);
  localparam logic [1:0] FAST_CYC  =
    2'((SYS_KHZ + FAST_KHZ - 1) / FAST_KHZ);
  localparam logic [1:0] VFAST_CYC =
    2'((SYS_KHZ + VFAST_KHZ - 1) / VFAST_KHZ);
  // ---------------------------------------------------------------
  // register map and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_COUNT  = 8'h08;
  localparam logic [7:0] OFS_LAST   = 8'h0C;
  localparam logic [7:0] OFS_TRACE  = 8'h40; // 16 words up to 0x7C
  localparam int CTRL_F1_LSB  = 0;
  localparam int CTRL_F2_LSB  = 4;
  localparam int CTRL_SPD_LSB = 8;
  localparam int CTRL_CNT_LSB = 12;
  localparam int CTRL_RUN_BIT = 16;
  localparam logic [16:0] CTRL_RST = 17'h0_0000;
  localparam int DATA_W   = 16; // probe channels
  localparam int TRACE_AW = 4;  // trace depth 16
  // edge of a pin chosen by its clock field
  function automatic logic edge_hit(input logic [2:0] m,
                                    input logic cur, input logic prv);
    edge_hit = ((m == CLK_RISE || m == CLK_BOTH) && cur && !prv) ||
               ((m == CLK_FALL || m == CLK_BOTH) && !cur && prv);
  endfunction
  // gate that a qualifier field puts on the other input
  function automatic logic qual_ok(input logic [2:0] m,
                                   input logic lvl);
    qual_ok = (m == CLK_HIGH) ? lvl : (m == CLK_LOW) ? !lvl : 1'b1;
  endfunction
endpackage
`default_nettype wire

// ==== cq_rate_gate.sv ====
// module: spacing gate that caps the qualified clock rate
`timescale 1ns/10ps
`default_nettype none
module cq_rate_gate
(
  input  wire logic       clk_i,   // system clock
  input  wire logic       rst_b_i, // sync reset, low active
  input  wire logic       ce_i,    // clock enable
  input  wire logic [1:0] speed_i, // speed setting
  input  wire logic       req_i,   // combined qualified edge
  output logic            grant_o, // edge accepted
  output logic            drop_o   // edge came too soon
);
  logic [1:0] since_reg;  // cycles since last grant, saturating
  logic [1:0] since_next; // its next value
  logic [1:0] min_cyc;    // least spacing for the speed
  // ---------------------------------------------------------------
  // spacing check over the merged edge stream
  // ---------------------------------------------------------------
  always_comb
  begin
    case (speed_i)
      cq_pkg::SPD_SLOW:  min_cyc = cq_pkg::SLOW_CYC;
      cq_pkg::SPD_FAST:  min_cyc = cq_pkg::FAST_CYC;
      default:           min_cyc = cq_pkg::VFAST_CYC;
    endcase
    grant_o = req_i && (since_reg >= min_cyc - 2'd1);
    drop_o  = req_i && !grant_o;
    if (!ce_i)
      since_next = since_reg;
    else if (grant_o)
      since_next = 2'd0;
    else if (since_reg != 2'd3)
      since_next = since_reg + 2'd1;
    else
      since_next = since_reg;
  end
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      since_reg <= 2'd3;
    else
      since_reg <= since_next;
  end
endmodule // cq_rate_gate
`default_nettype wire

// ==== cq_state_qualifier.sv ====
// module: external state analyzer clock qualifier with apb registers
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module cq_state_qualifier
(
  input  wire logic        CLK_SYS_I,    // 25 MHz system clock
  input  wire logic        RST_B_I,      // sync reset, low active
  input  wire logic        CE_I,         // freezes all state when low
  input  wire logic        PSEL_I,       // apb select
  input  wire logic        PENABLE_I,    // apb access phase
  input  wire logic        PWRITE_I,     // apb direction
  input  wire logic [7:0]  PADDR_I,      // apb byte address
  input  wire logic [31:0] PWDATA_I,     // apb write data
  output logic      [31:0] PRDATA_O,     // apb read data
  output logic             PREADY_O,     // apb ready
  output logic             PSLVERR_O,    // unmapped address
  input  wire logic        FIRST_EXT_CLOCK_IN_I,  // target clock one
  input  wire logic        SECOND_EXT_CLOCK_IN_I, // target clock two
  input  wire logic [15:0] PROBE_DATA_I, // probe channels
  output logic             SAMPLE_STROBE_O, // one pulse per sample
  output logic      [15:0] SAMPLE_DATA_O    // last captured state
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [16:0] ctrl_reg, ctrl_next;      // control word
  logic        ovr_reg, ovr_next;        // sticky rate overrun
  logic [31:0] cnt_reg, cnt_next;        // count qualifier
  logic [3:0]  wptr_reg, wptr_next;      // trace write pointer
  logic        wrap_reg, wrap_next;      // trace has wrapped
  logic        stb_reg, stb_next;        // sample strobe
  logic [15:0] last_reg, last_next;      // last sample
  logic [31:0] rdata_reg, rdata_next;    // apb read data
  logic        rdy_reg, rdy_next;        // apb ready
  logic        err_reg, err_next;        // apb error
  logic [15:0] trace_mem [16];           // trace memory
  logic [2:0]  mode1, mode2;             // clock fields
  logic [1:0]  speed, cnt_req, cnt_eff;  // speed and count modes
  logic        run;                      // capture enabled
  logic        hit1, hit2, prev1, prev2; // edge picker outputs
  logic        req, grant, drop;         // merged and gated edges
  logic        wr_acc, rd_setup, mapped; // bus decode
  logic        is_trace;                 // trace window hit

  assign mode1   = ctrl_reg[cq_pkg::CTRL_F1_LSB +: 3];
  assign mode2   = ctrl_reg[cq_pkg::CTRL_F2_LSB +: 3];
  assign speed   = ctrl_reg[cq_pkg::CTRL_SPD_LSB +: 2];
  assign cnt_req = ctrl_reg[cq_pkg::CTRL_CNT_LSB +: 2];
  assign run     = ctrl_reg[cq_pkg::CTRL_RUN_BIT];

  // ---------------------------------------------------------------
  // edge pickers, one per external input
  // ---------------------------------------------------------------
  cq_edge_select u_first
  (
    .clk_i   (CLK_SYS_I),
    .rst_b_i (RST_B_I),
    .ce_i    (CE_I),
    .mode_i  (mode1),
    .pin_i   (FIRST_EXT_CLOCK_IN_I),
    .hit_o   (hit1),
    .prev_o  (prev1)
  );
  cq_edge_select u_second
  (
    .clk_i   (CLK_SYS_I),
    .rst_b_i (RST_B_I),
    .ce_i    (CE_I),
    .mode_i  (mode2),
    .pin_i   (SECOND_EXT_CLOCK_IN_I),
    .hit_o   (hit2),
    .prev_o  (prev2)
  );

  // ---------------------------------------------------------------
  // qualification and merge
  // ---------------------------------------------------------------
  // only the two external inputs form the clock
  always_comb
  begin
    req = run && CE_I &&
      ((hit1 && cq_pkg::qual_ok(mode2, SECOND_EXT_CLOCK_IN_I)) ||
       (hit2 && cq_pkg::qual_ok(mode1, FIRST_EXT_CLOCK_IN_I)));
  end

  // rate cap over the merged stream
  cq_rate_gate u_rate
  (
    .clk_i   (CLK_SYS_I),
    .rst_b_i (RST_B_I),
    .ce_i    (CE_I),
    .speed_i (speed),
    .req_i   (req),
    .grant_o (grant),
    .drop_o  (drop)
  );

  // ---------------------------------------------------------------
  // count qualifier restriction by speed
  // ---------------------------------------------------------------
  always_comb
  begin
    case (speed)
      cq_pkg::SPD_SLOW:  cnt_eff = cnt_req;
      cq_pkg::SPD_FAST:  // time requests fall back to states
        cnt_eff = (cnt_req == cq_pkg::CNT_OFF) ? cq_pkg::CNT_OFF
                                                : cq_pkg::CNT_STATES;
      default:           cnt_eff = cq_pkg::CNT_OFF;
    endcase
  end

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  always_comb
  begin
    is_trace = PADDR_I[7:6] == cq_pkg::OFS_TRACE[7:6] &&
               PADDR_I[1:0] == 2'b00;
    mapped   = is_trace || PADDR_I == cq_pkg::OFS_CTRL ||
               PADDR_I == cq_pkg::OFS_STATUS ||
               PADDR_I == cq_pkg::OFS_COUNT ||
               PADDR_I == cq_pkg::OFS_LAST;
    rd_setup = CE_I && PSEL_I && !PENABLE_I;
    wr_acc   = CE_I && PSEL_I && PENABLE_I && rdy_reg && PWRITE_I &&
               mapped;
  end

  // ---------------------------------------------------------------
  // next state of control, capture and bus answer
  // ---------------------------------------------------------------
  always_comb
  begin
    ctrl_next  = ctrl_reg;
    ovr_next   = ovr_reg;
    cnt_next   = cnt_reg;
    wptr_next  = wptr_reg;
    wrap_next  = wrap_reg;
    stb_next   = 1'b0;
    last_next  = last_reg;
    rdata_next = rdata_reg;
    rdy_next   = 1'b0;
    err_next   = 1'b0;
    if (!CE_I)
    begin
      // frozen
      stb_next = stb_reg;
      rdy_next = rdy_reg;
      err_next = err_reg;
    end
    else
    begin
      // control write
      if (wr_acc && PADDR_I == cq_pkg::OFS_CTRL)
        ctrl_next = PWDATA_I[16:0];
      // overrun: write one clears, a new drop wins
      if (wr_acc && PADDR_I == cq_pkg::OFS_STATUS && PWDATA_I[0])
        ovr_next = 1'b0;
      if (drop)
        ovr_next = 1'b1;
      // one sample per accepted edge
      if (grant)
      begin
        stb_next  = 1'b1;
        last_next = PROBE_DATA_I;
        wptr_next = wptr_reg + 4'd1;
        if (wptr_reg == 4'hF)
          wrap_next = 1'b1;
      end
      // count qualifier
      if (run && cnt_eff == cq_pkg::CNT_STATES && grant)
        cnt_next = cnt_reg + 32'd1;
      else if (run && cnt_eff == cq_pkg::CNT_TIME)
        cnt_next = cnt_reg + 32'd1;
      // count clear on write, wins over counting
      if (wr_acc && PADDR_I == cq_pkg::OFS_COUNT)
        cnt_next = 32'h0000_0000;
      // read data prepared in the setup phase
      if (rd_setup)
      begin
        rdy_next   = 1'b1;
        err_next   = !mapped;
        rdata_next = 32'h0000_0000;
        if (PADDR_I == cq_pkg::OFS_CTRL)
          rdata_next = {15'h0000, ctrl_reg};
        else if (PADDR_I == cq_pkg::OFS_STATUS)
          rdata_next = {23'h00_0000, cnt_eff, wrap_reg, wptr_reg,
                        run, ovr_reg};
        else if (PADDR_I == cq_pkg::OFS_COUNT)
          rdata_next = cnt_reg;
        else if (PADDR_I == cq_pkg::OFS_LAST)
          rdata_next = {16'h0000, last_reg};
        else if (is_trace)
          rdata_next = {16'h0000, trace_mem[PADDR_I[5:2]]};
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_B_I)
    begin
      ctrl_reg  <= cq_pkg::CTRL_RST;
      ovr_reg   <= 1'b0;
      cnt_reg   <= 32'h0000_0000;
      wptr_reg  <= 4'h0;
      wrap_reg  <= 1'b0;
      stb_reg   <= 1'b0;
      last_reg  <= 16'h0000;
      rdata_reg <= 32'h0000_0000;
      rdy_reg   <= 1'b0;
      err_reg   <= 1'b0;
    end
    else
    begin
      ctrl_reg  <= ctrl_next;
      ovr_reg   <= ovr_next;
      cnt_reg   <= cnt_next;
      wptr_reg  <= wptr_next;
      wrap_reg  <= wrap_next;
      stb_reg   <= stb_next;
      last_reg  <= last_next;
      rdata_reg <= rdata_next;
      rdy_reg   <= rdy_next;
      err_reg   <= err_next;
    end
  end

  // trace memory write, no reset needed
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_B_I && grant)
      trace_mem[wptr_reg] <= PROBE_DATA_I;
  end

  assign PRDATA_O        = rdata_reg;
  assign PREADY_O        = rdy_reg;
  assign PSLVERR_O       = err_reg;
  assign SAMPLE_STROBE_O = stb_reg;
  assign SAMPLE_DATA_O   = last_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_rise;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
    run && CE_I && mode1 == cq_pkg::CLK_RISE &&
    mode2 == cq_pkg::CLK_OFF && FIRST_EXT_CLOCK_IN_I && !prev1
    |-> req;
  endproperty
  a_rise: assert property (p_rise)
    else $error("rising edge gave no clock");
  property p_fall;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
    mode1 == cq_pkg::CLK_FALL && mode2 == cq_pkg::CLK_OFF &&
    FIRST_EXT_CLOCK_IN_I |-> !req;
  endproperty
  a_fall: assert property (p_fall)
    else $error("falling setting clocked on a high level");
  property p_both;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
    run && CE_I && mode2 == cq_pkg::CLK_BOTH &&
    mode1 == cq_pkg::CLK_OFF &&
    SECOND_EXT_CLOCK_IN_I != prev2 |-> req;
  endproperty
  a_both: assert property (p_both)
    else $error("transition missed in both-edge setting");
  property p_high;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
    mode1 == cq_pkg::CLK_HIGH && !FIRST_EXT_CLOCK_IN_I |-> !req;
  endproperty
  a_high: assert property (p_high)
    else $error("edge passed while high qualifier low");
  property p_low;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
    mode2 == cq_pkg::CLK_LOW && SECOND_EXT_CLOCK_IN_I |-> !req;
  endproperty
  a_low: assert property (p_low)
    else $error("edge passed while low qualifier high");
  property p_off;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
    mode1 == cq_pkg::CLK_OFF && mode2 == cq_pkg::CLK_OFF |-> !req;
  endproperty
  a_off: assert property (p_off)
    else $error("clock seen with both inputs off");
  property p_space;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
    grant && CE_I && speed != cq_pkg::SPD_VFAST
    |=> !grant && (!req || drop);
  endproperty
  a_space: assert property (p_space)
    else $error("qualified clocks closer than speed allows");
  property p_vfast;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
    speed == cq_pkg::SPD_VFAST && CE_I |=> $stable(cnt_reg);
  endproperty
  a_vfast: assert property (p_vfast)
    else $error("count qualifier active at very fast speed");
  property p_fast;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
    speed == cq_pkg::SPD_FAST && !grant && CE_I
    && !wr_acc |=> $stable(cnt_reg);
  endproperty
  a_fast: assert property (p_fast)
    else $error("count qualifier counted time at fast speed");
  property p_capture;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
    grant |=> stb_reg && last_reg == $past(PROBE_DATA_I) &&
              wptr_reg == $past(wptr_reg) + 4'd1;
  endproperty
  a_capture: assert property (p_capture)
    else $error("accepted edge did not capture one sample");
endmodule // cq_state_qualifier
`default_nettype wire

// ==== target_system_model.sv ====
// target system model: drives both external clocks and the probes
`timescale 1ns/10ps
`default_nettype none
module target_system_model
(
  input  wire logic        clk_i,     // system clock
  output logic             clk_one_o, // first target clock
  output logic             clk_two_o, // second target clock
  output logic      [15:0] probe_o    // probe channels
);
  // -----------------------------------------------------------
  // idle levels, then fresh probe data at every rising edge
  // -----------------------------------------------------------
  initial
  begin
    clk_one_o = 1'b0;
    clk_two_o = 1'b0;
    probe_o   = 16'h0000;
  end
  always @(posedge clk_i)
  begin
    probe_o <= probe_o + 16'h0001; // never the same twice in a row
  end
  // plays one level per cycle on each clock line, lsb first
  task automatic play(input logic [7:0] one, input logic [7:0] two);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_i);
      clk_one_o <= one[i];
      clk_two_o <= two[i];
    end
  endtask
endmodule // target_system_model
`default_nettype wire

// ==== test_state_analyzer_clock_qualifier.sv ====
// testbench: clock qualifier driven over apb and by the target model
`timescale 1ns/10ps
`default_nettype none
module test_state_analyzer_clock_qualifier;
  // -----------------------------------------------------------
  // signals
  // -----------------------------------------------------------
  typedef struct {
    logic [2:0] f1, f2;   // clock fields
    logic [1:0] spd, cnt; // speed, count request
    logic [1:0] eff;      // expected effective count mode
    logic [7:0] p1, p2;   // pin patterns, lsb first
  } row_s;
  logic        clk = 1'b0;
  logic        rst_b, ce, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, er, pin1, pin2, strobe, ovr;
  logic [15:0] probe, sdata, probe_q, last_q;
  int          strobes = 0;
  int          checks = 0;
  int          miscompares = 0;
  int          n, n0;
  row_s        rows [11] = '{
    '{3'h1, 3'h0, 2'h0, 2'h2, 2'h2, 8'h66, 8'h5A},
    '{3'h2, 3'h0, 2'h1, 2'h2, 2'h1, 8'h66, 8'h5A},
    '{3'h3, 3'h0, 2'h2, 2'h1, 2'h0, 8'h2A, 8'h00},
    '{3'h0, 3'h3, 2'h0, 2'h1, 2'h1, 8'h00, 8'h2A},
    '{3'h1, 3'h4, 2'h0, 2'h0, 2'h0, 8'h66, 8'h0F},
    '{3'h1, 3'h5, 2'h0, 2'h0, 2'h0, 8'h66, 8'h0F},
    '{3'h4, 3'h2, 2'h1, 2'h1, 2'h1, 8'h3C, 8'h66},
    '{3'h1, 3'h1, 2'h1, 2'h0, 2'h0, 8'h06, 8'h30},
    '{3'h1, 3'h1, 2'h1, 2'h0, 2'h0, 8'h02, 8'h04},
    '{3'h1, 3'h1, 2'h0, 2'h0, 2'h0, 8'h06, 8'h06},
    '{3'h6, 3'h1, 2'h3, 2'h2, 2'h0, 8'h0F, 8'h66}
  };
  always #20 clk = ~clk; // 25 MHz
  // -----------------------------------------------------------
  // design and target model
  // -----------------------------------------------------------
  cq_state_qualifier DUT
  (
    .CLK_SYS_I             (clk),
    .RST_B_I               (rst_b),
    .CE_I                  (ce),
    .PSEL_I                (psel),
    .PENABLE_I             (penable),
    .PWRITE_I              (pwrite),
    .PADDR_I               (paddr),
    .PWDATA_I              (pwdata),
    .PRDATA_O              (prdata),
    .PREADY_O              (pready),
    .PSLVERR_O             (pslverr),
    .FIRST_EXT_CLOCK_IN_I  (pin1),
    .SECOND_EXT_CLOCK_IN_I (pin2),
    .PROBE_DATA_I          (probe),
    .SAMPLE_STROBE_O       (strobe),
    .SAMPLE_DATA_O         (sdata)
  );
  target_system_model target
  (
    .clk_i     (clk),
    .clk_one_o (pin1),
    .clk_two_o (pin2),
    .probe_o   (probe)
  );
  // -----------------------------------------------------------
  // helpers
  // -----------------------------------------------------------
  task automatic stop_test;
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // one apb transfer, waits for ready under a bound
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      $display("CHECK FAILED at %0t: no bus ready", $time);
      miscompares++;
      stop_test();
    end
  endtask
  // edge and gate seen by one pin under its clock field
  function automatic logic edg(input logic [2:0] m, input logic c,
                               input logic p);
    return ((m == cq_pkg::CLK_RISE || m == cq_pkg::CLK_BOTH) && c && !p)
        || ((m == cq_pkg::CLK_FALL || m == cq_pkg::CLK_BOTH) && !c && p);
  endfunction
  function automatic logic qok(input logic [2:0] m, input logic l);
    return (m == cq_pkg::CLK_HIGH) ? l : (m == cq_pkg::CLK_LOW) ? !l : 1'b1;
  endfunction
  // expected sample count and overrun for one row
  task automatic predict(input row_s r, output int cnt, output logic ov);
    int last;
    int sp;
    logic [7:0] q1;
    logic [7:0] q2;
    logic hit;
    cnt = 0;
    ov = 1'b0;
    last = -8;
    q1 = r.p1 << 1;
    q2 = r.p2 << 1;
    sp = (cq_pkg::SYS_KHZ + 24999) / 25000;
    if (r.spd == cq_pkg::SPD_SLOW)
      sp = (cq_pkg::SYS_KHZ + 15999) / 16000;
    if (r.spd == cq_pkg::SPD_FAST)
      sp = (cq_pkg::SYS_KHZ + 19999) / 20000;
    for (int i = 0; i < 8; i++)
    begin
      hit = (edg(r.f1, r.p1[i], q1[i]) && qok(r.f2, r.p2[i]))
         || (edg(r.f2, r.p2[i], q2[i]) && qok(r.f1, r.p1[i]));
      if (hit && i - last >= sp)
      begin
        cnt++;
        last = i;
      end
      else if (hit)
        ov = 1'b1;
    end
  endtask
  function automatic logic [31:0] ctrl(input row_s r, input logic run);
    ctrl = 32'h0000_0000;
    ctrl[cq_pkg::CTRL_F1_LSB +: 3] = r.f1;
    ctrl[cq_pkg::CTRL_F2_LSB +: 3] = r.f2;
    ctrl[cq_pkg::CTRL_SPD_LSB +: 2] = r.spd;
    ctrl[cq_pkg::CTRL_CNT_LSB +: 2] = r.cnt;
    ctrl[cq_pkg::CTRL_RUN_BIT] = run;
  endfunction
  // -----------------------------------------------------------
  // sample monitor: counts strobes, checks captured data
  // -----------------------------------------------------------
  always @(posedge clk)
  begin
    probe_q <= probe;
    if (strobe === 1'b1)
    begin
      strobes <= strobes + 1;
      last_q  <= probe_q;
      check(sdata === probe_q, "sample data");
    end
  end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    $display("CHECK FAILED at %0t: run too long", $time);
    miscompares++;
    stop_test();
  end
  // -----------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------
  initial
  begin
    rst_b = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, cq_pkg::OFS_CTRL, 32'h0000_0000);
    check(rd === 32'h0000_0000 && er === 1'b0, "ctrl reset value");
    apb(1'b0, cq_pkg::OFS_STATUS, 32'h0000_0000);
    check(rd === 32'h0000_0000, "status reset value");
    foreach (rows[i])
    begin
      predict(rows[i], n, ovr);
      n0 = strobes;
      apb(1'b1, cq_pkg::OFS_CTRL, ctrl(rows[i], 1'b1));
      apb(1'b0, cq_pkg::OFS_CTRL, 32'h0000_0000);
      check(rd === ctrl(rows[i], 1'b1), "ctrl readback");
      target.play(rows[i].p1, rows[i].p2);
      repeat (4) @(posedge clk);
      check(strobes - n0 == n, "sample count");
      apb(1'b0, cq_pkg::OFS_STATUS, 32'h0000_0000);
      check(rd[0] === ovr && rd[1] === 1'b1, "overrun flag");
      check(rd[8:7] === rows[i].eff, "count mode");
      check(rd[6:2] === {strobes > 15, 4'(strobes)}, "pointer");
      apb(1'b0, cq_pkg::OFS_LAST, 32'h0000_0000);
      check(rd === {16'h0000, last_q}, "last sample");
      apb(1'b0, cq_pkg::OFS_TRACE + 8'((strobes + 15) % 16 * 4),
          32'h0000_0000);
      check(rd === {16'h0000, last_q}, "trace word");
      apb(1'b1, cq_pkg::OFS_STATUS, 32'h0000_0001);
      apb(1'b1, cq_pkg::OFS_CTRL, 32'h0000_0000);
      apb(1'b0, cq_pkg::OFS_STATUS, 32'h0000_0000);
      check(rd[1:0] === 2'h0, "overrun clear");
    end
    // unmapped address refused, write ignored
    apb(1'b1, 8'h10, 32'h0001_0001);
    check(er === 1'b1, "unmapped write error");
    apb(1'b0, 8'h10, 32'h0000_0000);
    check(er === 1'b1 && rd === 32'h0000_0000, "unmapped read");
    apb(1'b0, cq_pkg::OFS_CTRL, 32'h0000_0000);
    check(rd === 32'h0000_0000, "ctrl untouched");
    // count register clears on any write
    apb(1'b1, cq_pkg::OFS_COUNT, 32'h0000_0000);
    apb(1'b0, cq_pkg::OFS_COUNT, 32'h0000_0000);
    check(rd === 32'h0000_0000, "count cleared");
    // stopped analyzer takes no samples
    n0 = strobes;
    target.play(8'h0F, 8'h33);
    repeat (4) @(posedge clk);
    check(strobes == n0, "no samples while stopped");
    // clock enable low freezes capture
    apb(1'b1, cq_pkg::OFS_CTRL, ctrl(rows[0], 1'b1));
    n0 = strobes;
    ce <= 1'b0;
    target.play(8'h66, 8'h00);
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    check(strobes == n0, "samples while clock enable low");
    // second reset in mid-run
    apb(1'b1, cq_pkg::OFS_CTRL, ctrl(rows[0], 1'b1));
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    check(strobe === 1'b0 && sdata === 16'h0000, "outputs in reset");
    rst_b <= 1'b1;
    apb(1'b0, cq_pkg::OFS_CTRL, 32'h0000_0000);
    check(rd === 32'h0000_0000, "ctrl after reset");
    stop_test();
  end
endmodule // test_state_analyzer_clock_qualifier
`default_nettype wire
